// [tsp_master.sv]
// Purpose: Bus master model that drives the two-wire link of the slave port.
// Assumes: Serial clock is 5 core cycles low and 3 high, a 200 ns period.
// Notes: Open drain; a released data line floats high on the pull-up.
`timescale 1ns/1ps
module tsp_master (
    input wire logic clock,
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Data moves mid-low; sampling late gives the slave's sync stages time
    task automatic bit_io(input logic b, output logic r);
        w(2);
        sda_low = !b;
        w(3);
        scl = 1'b1;
        r = sda_line;
        w(3);
        scl = 1'b0;
    endtask
    task automatic start();
        w(2);
        sda_low = 1'b0;
        w(3);
        scl = 1'b1;
        w(2);
        sda_low = 1'b1;
        w(2);
        scl = 1'b0;
    endtask
    task automatic stop();
        w(2);
        sda_low = 1'b1;
        w(3);
        scl = 1'b1;
        w(2);
        sda_low = 1'b0;
        w(4);
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule

// [tsp_pkg.sv]
// Purpose: Shared types and constants for the two-wire slave port.
// Assumes: 40 MHz core clock, bus master drives the serial clock.
// Notes: Register file lives outside; this port only reads and writes it.
package tsp_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int ID_W = 5;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;
    localparam int MSB = 7;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 8'h01;
    // Arbitrary neutral prefix; set per product
    localparam logic [ID_W-1:0] ID_PREFIX_DEF = 5'h0B;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK
    } tsp_phase_t;

    typedef enum logic [1:0] {
        K_DEV,
        K_REG,
        K_DATA
    } tsp_kind_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
    } tsp_reg_req_t;

    typedef struct packed {
        logic [1:0] scl_s;
        logic scl_p;
        logic [1:0] sda_s;
        logic sda_p;
        logic [1:0] ahi_s;
        logic [1:0] alo_s;
        tsp_phase_t st;
        tsp_kind_t kind;
        logic rw;
        logic [3:0] cnt;
        logic [DATA_W-1:0] sh;
        logic oe;
        logic mack;
        tsp_reg_req_t req;
    } tsp_state_t;

    localparam tsp_state_t STATE_RESET = '0;

endpackage

// [tsp_slave_port.sv]
// Purpose: Two-wire serial slave port into the internal register space.
// Assumes: Pins are asynchronous and pass two flops; reg_rdata is same clock.
// Notes: Open-drain data pin: only ever drives low, sda_oe high while driving.
`timescale 1ns/1ps
module tsp_slave_port #(
    parameter logic [tsp_pkg::ID_W-1:0] ID_PREFIX = tsp_pkg::ID_PREFIX_DEF
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_select_hi_pin,
    input wire logic addr_select_lo_pin,
    input wire logic powerup_busy,
    output tsp_pkg::tsp_reg_req_t reg_req,
    input wire logic [tsp_pkg::DATA_W-1:0] reg_rdata
);

    tsp_pkg::tsp_state_t q;
    tsp_pkg::tsp_state_t d;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda;
    logic [tsp_pkg::MSB-1:0] own_addr;

    // Edges come from the second and third stages only
    assign sda = q.sda_s[1];
    assign scl_rise = q.scl_s[1] & ~q.scl_p;
    assign scl_fall = ~q.scl_s[1] & q.scl_p;
    assign start_det = q.scl_s[1] & q.scl_p & ~q.sda_s[1] & q.sda_p;
    assign stop_det = q.scl_s[1] & q.scl_p & q.sda_s[1] & ~q.sda_p;
    assign own_addr = {ID_PREFIX, q.ahi_s[1], q.alo_s[1]};

    always_comb begin
        d = q;
        d.scl_s = {q.scl_s[0], scl_i};
        d.scl_p = q.scl_s[1];
        d.sda_s = {q.sda_s[0], sda_i};
        d.sda_p = q.sda_s[1];
        d.ahi_s = {q.ahi_s[0], addr_select_hi_pin};
        d.alo_s = {q.alo_s[0], addr_select_lo_pin};
        d.req.we = 1'b0;
        if (stop_det) begin
            // A half-done write never reaches the strobe
            d.st = tsp_pkg::ST_IDLE;
            d.oe = 1'b0;
        end else if (start_det && !powerup_busy) begin
            // Repeated start keeps the pointer for a random read
            d.st = tsp_pkg::ST_RX;
            d.kind = tsp_pkg::K_DEV;
            d.cnt = tsp_pkg::CNT_ZERO;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                tsp_pkg::ST_IDLE: begin
                    d.oe = 1'b0;
                end
                tsp_pkg::ST_RX: begin
                    if (scl_rise) begin
                        d.sh = {q.sh[tsp_pkg::MSB-1:0], sda};
                        d.cnt = q.cnt + tsp_pkg::CNT_ONE;
                    end else if (scl_fall && q.cnt == tsp_pkg::BYTE_BITS) begin
                        d.cnt = tsp_pkg::CNT_ZERO;
                        if (q.kind == tsp_pkg::K_DEV) begin
                            if (q.sh[tsp_pkg::MSB:1] == own_addr) begin
                                d.rw = q.sh[0];
                                d.st = tsp_pkg::ST_ACK;
                                d.oe = 1'b1;
                            end else begin
                                d.st = tsp_pkg::ST_IDLE;
                            end
                        end else begin
                            d.st = tsp_pkg::ST_ACK;
                            d.oe = 1'b1;
                            if (q.kind == tsp_pkg::K_REG) begin
                                d.req.addr = q.sh;
                            end
                        end
                    end
                end
                tsp_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        d.oe = 1'b0;
                        d.cnt = tsp_pkg::CNT_ZERO;
                        if (q.kind == tsp_pkg::K_DEV && q.rw) begin
                            d.st = tsp_pkg::ST_TX;
                            d.sh = reg_rdata;
                            d.oe = ~reg_rdata[tsp_pkg::MSB];
                        end else begin
                            d.st = tsp_pkg::ST_RX;
                            // Write only once the data byte's ack clock is over
                            if (q.kind == tsp_pkg::K_DATA) begin
                                d.req.we = 1'b1;
                                d.req.wdata = q.sh;
                            end
                            d.kind = (q.kind == tsp_pkg::K_DEV) ? tsp_pkg::K_REG
                                                                : tsp_pkg::K_DATA;
                        end
                    end
                end
                tsp_pkg::ST_TX: begin
                    if (scl_rise) begin
                        d.cnt = q.cnt + tsp_pkg::CNT_ONE;
                    end else if (scl_fall) begin
                        if (q.cnt == tsp_pkg::BYTE_BITS) begin
                            d.oe = 1'b0;
                            d.st = tsp_pkg::ST_MACK;
                        end else begin
                            d.sh = {q.sh[tsp_pkg::MSB-1:0], 1'b0};
                            d.oe = ~q.sh[tsp_pkg::MSB-1];
                        end
                    end
                end
                tsp_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        d.mack = ~sda;
                        if (!sda) begin
                            d.req.addr = q.req.addr + tsp_pkg::ADDR_STEP;
                        end
                    end else if (scl_fall) begin
                        d.cnt = tsp_pkg::CNT_ZERO;
                        if (q.mack) begin
                            // Pointer moved at the rising edge, so data is settled
                            d.st = tsp_pkg::ST_TX;
                            d.sh = reg_rdata;
                            d.oe = ~reg_rdata[tsp_pkg::MSB];
                        end else begin
                            d.st = tsp_pkg::ST_IDLE;
                            d.oe = 1'b0;
                        end
                    end
                end
                default: begin
                    d.st = tsp_pkg::ST_IDLE;
                    d.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            q <= tsp_pkg::STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // Slave only: the clock pin is never driven
    assign sda_o = 1'b0;
    assign sda_oe = q.oe;
    assign reg_req = q.req;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    property p_idle_release;
        q.st == tsp_pkg::ST_IDLE |-> !sda_oe;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data pin driven while idle");

    property p_stop_idle;
        stop_det |=> q.st == tsp_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle)
        else $error("stop did not return port to idle");

    property p_busy_start;
        start_det && powerup_busy && q.st == tsp_pkg::ST_IDLE |=> q.st == tsp_pkg::ST_IDLE;
    endproperty
    a_busy_start: assert property (p_busy_start)
        else $error("start accepted during power-up");

    property p_we_cause;
        reg_req.we |-> $past(q.st) == tsp_pkg::ST_ACK && $past(q.kind) == tsp_pkg::K_DATA
            && $past(scl_fall) && !$past(stop_det);
    endproperty
    a_we_cause: assert property (p_we_cause)
        else $error("write strobe without completed data byte");

    property p_rx_release;
        q.st == tsp_pkg::ST_RX |-> !sda_oe;
    endproperty
    a_rx_release: assert property (p_rx_release)
        else $error("data pin driven while master sends");

    property p_mismatch;
        q.st == tsp_pkg::ST_RX && q.kind == tsp_pkg::K_DEV && scl_fall
            && q.cnt == tsp_pkg::BYTE_BITS && q.sh[tsp_pkg::MSB:1] != own_addr
            && !stop_det && !start_det |=> q.st == tsp_pkg::ST_IDLE && !sda_oe;
    endproperty
    a_mismatch: assert property (p_mismatch)
        else $error("foreign address acknowledged");

    property p_match_ack;
        q.st == tsp_pkg::ST_RX && q.kind == tsp_pkg::K_DEV && scl_fall
            && q.cnt == tsp_pkg::BYTE_BITS && q.sh[tsp_pkg::MSB:1] == own_addr
            && !stop_det && !start_det |=> sda_oe && q.rw == $past(q.sh[0]);
    endproperty
    a_match_ack: assert property (p_match_ack)
        else $error("own address not acknowledged");

    property p_ptr_step;
        q.st == tsp_pkg::ST_MACK && scl_rise && !sda && !stop_det && !start_det
            |=> reg_req.addr == $past(reg_req.addr) + tsp_pkg::ADDR_STEP;
    endproperty
    a_ptr_step: assert property (p_ptr_step)
        else $error("pointer did not step after read ack");

    property p_tx_msb;
        q.st == tsp_pkg::ST_TX && q.cnt != tsp_pkg::BYTE_BITS |-> sda_oe == ~q.sh[tsp_pkg::MSB];
    endproperty
    a_tx_msb: assert property (p_tx_msb)
        else $error("transmit bit is not the shift register top bit");

    property p_nack_end;
        q.st == tsp_pkg::ST_MACK && !q.mack && scl_fall && !stop_det && !start_det
            |=> q.st == tsp_pkg::ST_IDLE ##1 !sda_oe;
    endproperty
    a_nack_end: assert property (p_nack_end)
        else $error("port kept driving after master nack");

    property p_reg_load;
        q.st == tsp_pkg::ST_RX && q.kind == tsp_pkg::K_REG && scl_fall
            && q.cnt == tsp_pkg::BYTE_BITS && !stop_det && !start_det
            |=> reg_req.addr == $past(q.sh) && sda_oe;
    endproperty
    a_reg_load: assert property (p_reg_load)
        else $error("register address not loaded");

    property p_ack_drive;
        q.st == tsp_pkg::ST_ACK |-> sda_oe;
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("data pin released during acknowledge clock");

    property p_byte_ack;
        q.st == tsp_pkg::ST_RX && q.kind != tsp_pkg::K_DEV && scl_fall
            && q.cnt == tsp_pkg::BYTE_BITS && !stop_det && !start_det
            |=> q.st == tsp_pkg::ST_ACK && sda_oe;
    endproperty
    a_byte_ack: assert property (p_byte_ack)
        else $error("received byte not acknowledged");

    property p_we_data;
        reg_req.we |-> reg_req.wdata == $past(q.sh);
    endproperty
    a_we_data: assert property (p_we_data)
        else $error("write data is not the received byte");

    property p_mack_release;
        q.st == tsp_pkg::ST_MACK |-> !sda_oe;
    endproperty
    a_mack_release: assert property (p_mack_release)
        else $error("data pin driven while master acknowledges");

    property p_next_byte;
        q.st == tsp_pkg::ST_MACK && q.mack && scl_fall && !stop_det && !start_det
            |=> q.st == tsp_pkg::ST_TX && q.sh == $past(reg_rdata);
    endproperty
    a_next_byte: assert property (p_next_byte)
        else $error("acked read did not load the next byte");

    property p_start_rx;
        start_det && !stop_det && !powerup_busy
            |=> q.st == tsp_pkg::ST_RX && q.kind == tsp_pkg::K_DEV
                && q.cnt == tsp_pkg::CNT_ZERO;
    endproperty
    a_start_rx: assert property (p_start_rx)
        else $error("start did not open an address byte");

    // A withheld ack must not move the pointer, or a later current read skips a register
    property p_nack_hold;
        q.st == tsp_pkg::ST_MACK && scl_rise && sda && !stop_det && !start_det
            |=> reg_req.addr == $past(reg_req.addr);
    endproperty
    a_nack_hold: assert property (p_nack_hold)
        else $error("pointer stepped without a read ack");

    c_write: cover property (reg_req.we);
    c_read_next: cover property (q.st == tsp_pkg::ST_MACK && q.mack && scl_fall);
    c_nack: cover property (q.st == tsp_pkg::ST_MACK && !q.mack && scl_fall);
    c_busy_start: cover property (start_det && powerup_busy);
    c_rep_start: cover property (start_det && q.st != tsp_pkg::ST_IDLE);

endmodule

// [tsp_slave_port_tb.sv]
// Purpose: Self-checking bench for the two-wire slave port.
// Assumes: Register file is a plain array answering in the same cycle.
// Notes: Register contents start as address xor 5A to spot stray writes.
`timescale 1ns/1ps
module tsp_slave_port_tb;
    localparam logic [4:0] PFX = 5'h0B;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic hi_pin = 1'b0;
    logic lo_pin = 1'b0;
    logic busy = 1'b0;
    logic scl, sda_low, sda_o, sda_oe, sda_line, a;
    logic [7:0] d;
    tsp_pkg::tsp_reg_req_t reg_req;
    logic [7:0] mem [256];
    int error_cnt = 0;
    int comparisons = 0;
    always #12.5 clock = ~clock;
    assign sda_line = (sda_oe ? sda_o : 1'b1) & ~sda_low;
    tsp_slave_port #(.ID_PREFIX(PFX)) u_tsp_slave_port (
        .clock(clock), .nrst(nrst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_hi_pin(hi_pin), .addr_select_lo_pin(lo_pin),
        .powerup_busy(busy), .reg_req(reg_req), .reg_rdata(mem[reg_req.addr]));
    tsp_master u_tsp_master (.clock(clock), .scl(scl), .sda_low(sda_low), .sda_line(sda_line));
    always @(posedge clock) begin
        if (reg_req.we === 1'b1) begin
            mem[reg_req.addr] <= reg_req.wdata;
        end
    end
    function automatic logic [7:0] iv(input logic [7:0] x);
        return x ^ 8'h5A;
    endfunction
    function automatic logic [7:0] adr(input logic [1:0] s, input logic rd);
        return {PFX, s, rd};
    endfunction
    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: %s is %b", $time, what, got);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: %s is %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] r, input logic [7:0] v);
        u_tsp_master.start();
        u_tsp_master.put(adr(2'h0, 1'b0), a);
        chk_bit(a, 1'b1, "write address ack");
        u_tsp_master.put(r, a);
        chk_bit(a, 1'b1, "register byte ack");
        u_tsp_master.put(v, a);
        chk_bit(a, 1'b1, "data byte ack");
        u_tsp_master.stop();
    endtask
    task automatic t_powerup();
        chk_bit(sda_oe, 1'b0, "released after reset");
        busy = 1'b1;
        u_tsp_master.start();
        u_tsp_master.put(adr(2'h0, 1'b0), a);
        chk_bit(a, 1'b0, "ack during power-up");
        u_tsp_master.stop();
        busy = 1'b0;
    endtask
    task automatic t_select();
        for (int s = 0; s < 4; s++) begin
            {hi_pin, lo_pin} = s[1:0];
            u_tsp_master.start();
            u_tsp_master.put(adr(s[1:0], 1'b0), a);
            chk_bit(a, 1'b1, "matching address ack");
            u_tsp_master.stop();
            u_tsp_master.start();
            u_tsp_master.put(adr(~s[1:0], 1'b0), a);
            chk_bit(a, 1'b0, "foreign address ack");
            u_tsp_master.stop();
        end
        {hi_pin, lo_pin} = 2'h0;
    endtask
    task automatic t_abort();
        u_tsp_master.start();
        u_tsp_master.put(adr(2'h0, 1'b0), a);
        u_tsp_master.put(8'h20, a);
        for (int i = 0; i < 4; i++) begin
            u_tsp_master.bit_io(1'b0, a);
        end
        u_tsp_master.stop();
        u_tsp_master.w(4);
        chk_byte(mem[8'h20], iv(8'h20), "aborted write target");
        wr(8'h21, 8'h96);
        chk_byte(mem[8'h21], 8'h96, "write after abort");
    endtask
    // Byte 1D is not a bit palindrome, so a reversed shift order shows up
    task automatic t_rand_read();
        wr(8'h10, 8'h1D);
        chk_byte(mem[8'h10], 8'h1D, "written register");
        u_tsp_master.start();
        u_tsp_master.put(adr(2'h0, 1'b0), a);
        u_tsp_master.put(8'h10, a);
        chk_bit(a, 1'b1, "pointer byte ack");
        u_tsp_master.start();
        u_tsp_master.put(adr(2'h0, 1'b1), a);
        chk_bit(a, 1'b1, "read address ack");
        u_tsp_master.get(1'b1, d);
        chk_byte(d, 8'h1D, "first read byte");
        u_tsp_master.get(1'b1, d);
        chk_byte(d, iv(8'h11), "second read byte");
        u_tsp_master.get(1'b0, d);
        chk_byte(d, iv(8'h12), "last read byte");
        u_tsp_master.w(4);
        chk_bit(sda_oe, 1'b0, "drive after nack");
        u_tsp_master.stop();
    endtask
    task automatic t_cur_read();
        wr(8'h30, 8'hC2);
        u_tsp_master.start();
        u_tsp_master.put(adr(2'h0, 1'b1), a);
        chk_bit(a, 1'b1, "current read ack");
        u_tsp_master.get(1'b0, d);
        chk_byte(d, 8'hC2, "current read byte");
        u_tsp_master.stop();
    endtask
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = iv(i[7:0]);
        end
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        u_tsp_master.w(4);
        t_powerup();
        t_select();
        t_abort();
        t_rand_read();
        t_cur_read();
        end_sim();
    end
    // Whole run is near 60 us; ten times that means a hang
    initial begin
        #600000;
        error_cnt++;
        end_sim();
    end
endmodule
